// ---- rtl/cpsc_pkg.sv ----
// Constants and types shared by the processing state controller.
// Assumes a single 40 MHz system clock domain for every user of the package.
package cpsc_pkg;

    // =====================================================================
    // Widths
    localparam int ADDR_W = 32;
    localparam int STAT_W = 32;
    localparam int LVL_W  = 4;
    localparam int WAIT_W = 16;
    localparam int MOD_N  = 3;

    // =====================================================================
    // Addresses and reset values
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'ha000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 32'h0000_0000;
    localparam logic [STAT_W-1:0] STAT_RST     = 32'h0000_0000;
    localparam logic [MOD_N-1:0]  MOD_ALL_ON   = 3'h7;
    localparam logic [MOD_N-1:0]  MOD_ALL_OFF  = 3'h0;

    // =====================================================================
    // Module stop bit positions
    localparam int MOD_TIMER  = 0;
    localparam int MOD_RTC    = 1;
    localparam int MOD_SERIAL = 2;

    // =====================================================================
    // Processing state codes shown to the outside
    localparam logic [2:0] PS_RESET  = 3'h0;
    localparam logic [2:0] PS_EXCP   = 3'h1;
    localparam logic [2:0] PS_BUSREL = 3'h2;
    localparam logic [2:0] PS_EXEC   = 3'h3;
    localparam logic [2:0] PS_PWRDN  = 3'h4;

    // Reset kind codes.
    localparam logic RK_POWER_ON = 1'b0;
    localparam logic RK_MANUAL   = 1'b1;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int OSC_STAB_NS    = 10000;
    localparam int OSC_STAB_CYC   = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [WAIT_W-1:0] OSC_STAB_CNT = WAIT_W'(OSC_STAB_CYC);
    localparam logic [WAIT_W-1:0] WAIT_ONE     = 16'h0001;
    localparam logic [WAIT_W-1:0] WAIT_ZERO    = 16'h0000;

    // =====================================================================
    // Types
    typedef enum logic [2:0] {
        ST_RESET,
        ST_EXC,
        ST_EXEC,
        ST_BUSREL,
        ST_SLEEP,
        ST_STANDBY,
        ST_OSCWAIT,
        ST_HWSTBY
    } cpsc_state_e;

    typedef enum logic [1:0] {
        CAUSE_RESET,
        CAUSE_EXC,
        CAUSE_IRQ
    } cpsc_cause_e;

endpackage

// ---- rtl/cpsc_sync.sv ----
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit changes slowly compared with the clock; bits are not coherent.
`timescale 1ns/10ps
module cpsc_sync #(
    parameter int          WIDTH    = 1,
    parameter logic [31:0] RST_VAL  = 32'h0000_0000
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= RST_VAL[WIDTH-1:0];
            sync_q <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ---- rtl/cpsc_top.sv ----
// Processing state controller: reset, exception entry, execution, bus release, power-down.
// Assumes the core, interrupt controller and watchdog share ref_clk_in; pins are asynchronous.
// Function
// - Processor is always in exactly one of five processing states.
// - Reset pin low: bus request pin high gives power-on, low gives manual.
// - Exception processing is transient, left once the handler fetch starts.
// - After any reset the program counter is loaded with the reset vector.
// - General exception or interrupt saves PC and status into saved registers.
// - Handler address is vector base plus offset, then program execution follows.
// - Halt with standby select 0 enters sleep; peripherals keep running.
// - Reset or interrupt wakes sleep through exception processing to execution.
// - Halt with standby select 1 enters standby; core, peripherals, oscillator stop.
// - Standby exit waits oscillator stabilization; interrupt exit uses watchdog time.
// - Hardware standby pin low halts all modules except the real-time clock.
// - Module stop bit 1 gates that module clock in execution and sleep.
// - Stopped timer pins hold; stopped serial pins return to reset state.
// - Clock gating ends when stop bits clear or any reset occurs.
// - Granted bus request enters bus release until the request ends.
`timescale 1ns/10ps
module cpsc_top (
    input  wire logic                         ref_clk_in,
    input  wire logic                         arst_n_in,
    input  wire logic                         reset_pin_n_in,
    input  wire logic                         bus_request_pin_n_in,
    input  wire logic                         hw_standby_pin_n_in,
    input  wire logic                         halt_exec_in,
    input  wire logic                         standby_select_bit_in,
    input  wire logic [cpsc_pkg::MOD_N-1:0]   module_stop_bit_in,
    input  wire logic                         gen_exc_in,
    input  wire logic                         irq_req_in,
    input  wire logic [cpsc_pkg::LVL_W-1:0]   irq_level_in,
    input  wire logic [cpsc_pkg::LVL_W-1:0]   irq_mask_in,
    input  wire logic [cpsc_pkg::ADDR_W-1:0]  pc_in,
    input  wire logic [cpsc_pkg::STAT_W-1:0]  status_in,
    input  wire logic [cpsc_pkg::ADDR_W-1:0]  vector_base_in,
    input  wire logic [cpsc_pkg::ADDR_W-1:0]  exc_offset_in,
    input  wire logic [cpsc_pkg::ADDR_W-1:0]  irq_offset_in,
    input  wire logic [cpsc_pkg::WAIT_W-1:0]  osc_wait_cycles_in,
    output logic      [2:0]                   proc_state_out,
    output logic                              reset_kind_out,
    output logic                              pc_load_out,
    output logic      [cpsc_pkg::ADDR_W-1:0]  pc_load_addr_out,
    output logic      [cpsc_pkg::ADDR_W-1:0]  saved_pc_reg_out,
    output logic      [cpsc_pkg::STAT_W-1:0]  saved_status_reg_out,
    output logic                              core_halt_out,
    output logic                              periph_clk_en_out,
    output logic                              osc_en_out,
    output logic      [cpsc_pkg::MOD_N-1:0]   module_clk_en_out,
    output logic                              timer_pin_hold_out,
    output logic                              serial_pin_reset_out,
    output logic                              bus_grant_out
);

    // =====================================================================
    // Reset release and pin synchronisation
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [2:0] pin_sync;
    logic       rst_low;
    logic       bus_request_pin_low;
    logic       hw_low;
    logic       irq_ok;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins idle high, so the synchroniser resets to the inactive level.
    cpsc_sync #(
        .WIDTH   (3),
        .RST_VAL (32'h0000_0007)
    ) u_pin_sync (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n),
        .async_in ({hw_standby_pin_n_in, bus_request_pin_n_in, reset_pin_n_in}),
        .sync_out (pin_sync)
    );

    assign rst_low  = ~pin_sync[0];
    assign bus_request_pin_low = ~pin_sync[1];
    assign hw_low   = ~pin_sync[2];
    assign irq_ok   = irq_req_in && (irq_level_in > irq_mask_in);

    // =====================================================================
    // Next processing state
    cpsc_pkg::cpsc_state_e state_q;
    cpsc_pkg::cpsc_state_e state_d;
    cpsc_pkg::cpsc_cause_e cause_q;
    cpsc_pkg::cpsc_cause_e cause_d;
    logic [cpsc_pkg::WAIT_W-1:0] wait_q;
    logic [cpsc_pkg::WAIT_W-1:0] wait_load;
    logic                        standby_select_bit_wake_q;
    logic                        in_pwrdn;
    logic [cpsc_pkg::ADDR_W-1:0] handler_calc;

    always_comb begin
        state_d   = state_q;
        cause_d   = cause_q;
        wait_load = cpsc_pkg::OSC_STAB_CNT;
        case (state_q)
            cpsc_pkg::ST_RESET: begin
                if (standby_select_bit_wake_q) begin
                    state_d = cpsc_pkg::ST_OSCWAIT;
                end else begin
                    state_d = cpsc_pkg::ST_EXC;
                end
                cause_d = cpsc_pkg::CAUSE_RESET;
            end
            cpsc_pkg::ST_EXC: begin
                state_d = cpsc_pkg::ST_EXEC;
            end
            cpsc_pkg::ST_EXEC: begin
                if (bus_request_pin_low) begin
                    state_d = cpsc_pkg::ST_BUSREL;
                end else if (gen_exc_in) begin
                    state_d = cpsc_pkg::ST_EXC;
                    cause_d = cpsc_pkg::CAUSE_EXC;
                end else if (irq_ok) begin
                    state_d = cpsc_pkg::ST_EXC;
                    cause_d = cpsc_pkg::CAUSE_IRQ;
                end else if (halt_exec_in) begin
                    // The select bit is looked at only here, so later writes cannot change the mode.
                    if (standby_select_bit_in) begin
                        state_d = cpsc_pkg::ST_STANDBY;
                    end else begin
                        state_d = cpsc_pkg::ST_SLEEP;
                    end
                end
            end
            cpsc_pkg::ST_BUSREL: begin
                if (!bus_request_pin_low) begin
                    state_d = cpsc_pkg::ST_EXEC;
                end
            end
            cpsc_pkg::ST_SLEEP: begin
                if (irq_ok) begin
                    state_d = cpsc_pkg::ST_EXC;
                    cause_d = cpsc_pkg::CAUSE_IRQ;
                end
            end
            cpsc_pkg::ST_STANDBY: begin
                if (irq_ok) begin
                    state_d = cpsc_pkg::ST_OSCWAIT;
                    cause_d = cpsc_pkg::CAUSE_IRQ;
                    if (osc_wait_cycles_in == cpsc_pkg::WAIT_ZERO) begin
                        wait_load = cpsc_pkg::WAIT_ONE;
                    end else begin
                        wait_load = osc_wait_cycles_in;
                    end
                end
            end
            cpsc_pkg::ST_OSCWAIT: begin
                if (wait_q == cpsc_pkg::WAIT_ONE) begin
                    state_d = cpsc_pkg::ST_EXC;
                end
            end
            cpsc_pkg::ST_HWSTBY: begin
                if (!hw_low) begin
                    state_d = cpsc_pkg::ST_OSCWAIT;
                    cause_d = cpsc_pkg::CAUSE_RESET;
                end
            end
            default: begin
                state_d = cpsc_pkg::ST_RESET;
                cause_d = cpsc_pkg::CAUSE_RESET;
            end
        endcase
        if (hw_low) begin
            state_d = cpsc_pkg::ST_HWSTBY;
            cause_d = cpsc_pkg::CAUSE_RESET;
        end
        if (rst_low) begin
            state_d = cpsc_pkg::ST_RESET;
            cause_d = cpsc_pkg::CAUSE_RESET;
        end
    end

    assign in_pwrdn = (state_q == cpsc_pkg::ST_STANDBY) || (state_q == cpsc_pkg::ST_OSCWAIT) ||
                      (state_q == cpsc_pkg::ST_HWSTBY);

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cpsc_pkg::ST_RESET;
            cause_q <= cpsc_pkg::CAUSE_RESET;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
        end
    end

    // A reset that interrupts a stopped oscillator must still wait for it to settle.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            standby_select_bit_wake_q <= 1'b0;
        end else if (state_q != cpsc_pkg::ST_RESET && state_d == cpsc_pkg::ST_RESET) begin
            standby_select_bit_wake_q <= in_pwrdn;
        end else if (state_q == cpsc_pkg::ST_RESET && state_d != cpsc_pkg::ST_RESET) begin
            standby_select_bit_wake_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= cpsc_pkg::WAIT_ZERO;
        end else if (state_d == cpsc_pkg::ST_OSCWAIT && state_q != cpsc_pkg::ST_OSCWAIT) begin
            wait_q <= wait_load;
        end else if (state_q == cpsc_pkg::ST_OSCWAIT && wait_q != cpsc_pkg::WAIT_ZERO) begin
            wait_q <= wait_q - cpsc_pkg::WAIT_ONE;
        end
    end

    // Sampled while the pin is low; hardware standby exit counts as power-on.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reset_kind_out <= cpsc_pkg::RK_POWER_ON;
        end else if (state_q == cpsc_pkg::ST_RESET && rst_low) begin
            reset_kind_out <= bus_request_pin_low ? cpsc_pkg::RK_MANUAL : cpsc_pkg::RK_POWER_ON;
        end else if (state_q == cpsc_pkg::ST_HWSTBY) begin
            reset_kind_out <= cpsc_pkg::RK_POWER_ON;
        end
    end

    // =====================================================================
    // Exception entry: save context and form the branch target
    assign handler_calc = vector_base_in + ((cause_d == cpsc_pkg::CAUSE_IRQ) ? irq_offset_in : exc_offset_in);

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            saved_pc_reg_out     <= cpsc_pkg::ADDR_RST;
            saved_status_reg_out <= cpsc_pkg::STAT_RST;
        end else if (state_d == cpsc_pkg::ST_EXC && state_q != cpsc_pkg::ST_EXC &&
                     cause_d != cpsc_pkg::CAUSE_RESET) begin
            saved_pc_reg_out     <= pc_in;
            saved_status_reg_out <= status_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_out      <= 1'b0;
            pc_load_addr_out <= cpsc_pkg::ADDR_RST;
        end else begin
            pc_load_out <= (state_d == cpsc_pkg::ST_EXC);
            if (state_d == cpsc_pkg::ST_EXC && state_q != cpsc_pkg::ST_EXC) begin
                if (cause_d == cpsc_pkg::CAUSE_RESET) begin
                    pc_load_addr_out <= cpsc_pkg::RESET_VECTOR;
                end else begin
                    pc_load_addr_out <= handler_calc;
                end
            end
        end
    end

    // =====================================================================
    // Power, clock and bus outputs
    logic stop_all;
    logic osc_off;

    always_comb begin
        stop_all = (state_d == cpsc_pkg::ST_STANDBY) || (state_d == cpsc_pkg::ST_OSCWAIT) ||
                   (state_d == cpsc_pkg::ST_HWSTBY);
        osc_off  = (state_d == cpsc_pkg::ST_STANDBY) || (state_d == cpsc_pkg::ST_HWSTBY);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            proc_state_out <= cpsc_pkg::PS_RESET;
            core_halt_out  <= 1'b1;
            bus_grant_out  <= 1'b0;
        end else begin
            case (state_d)
                cpsc_pkg::ST_RESET:  proc_state_out <= cpsc_pkg::PS_RESET;
                cpsc_pkg::ST_EXC:    proc_state_out <= cpsc_pkg::PS_EXCP;
                cpsc_pkg::ST_EXEC:   proc_state_out <= cpsc_pkg::PS_EXEC;
                cpsc_pkg::ST_BUSREL: proc_state_out <= cpsc_pkg::PS_BUSREL;
                default:             proc_state_out <= cpsc_pkg::PS_PWRDN;
            endcase
            core_halt_out <= (state_d == cpsc_pkg::ST_RESET) || (state_d == cpsc_pkg::ST_SLEEP) || stop_all;
            bus_grant_out <= (state_d == cpsc_pkg::ST_BUSREL);
        end
    end

    // Only the real-time clock survives the standby modes; its stop bit still applies.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            periph_clk_en_out    <= 1'b1;
            osc_en_out           <= 1'b1;
            module_clk_en_out    <= cpsc_pkg::MOD_ALL_ON;
            timer_pin_hold_out   <= 1'b0;
            serial_pin_reset_out <= 1'b0;
        end else if (state_d == cpsc_pkg::ST_RESET) begin
            periph_clk_en_out    <= 1'b1;
            osc_en_out           <= 1'b1;
            module_clk_en_out    <= cpsc_pkg::MOD_ALL_ON;
            timer_pin_hold_out   <= 1'b0;
            serial_pin_reset_out <= 1'b0;
        end else begin
            periph_clk_en_out <= !stop_all;
            osc_en_out        <= !osc_off;
            module_clk_en_out[cpsc_pkg::MOD_TIMER]  <= !stop_all && !module_stop_bit_in[cpsc_pkg::MOD_TIMER];
            module_clk_en_out[cpsc_pkg::MOD_SERIAL] <= !stop_all && !module_stop_bit_in[cpsc_pkg::MOD_SERIAL];
            module_clk_en_out[cpsc_pkg::MOD_RTC]    <= !module_stop_bit_in[cpsc_pkg::MOD_RTC];
            timer_pin_hold_out   <= module_stop_bit_in[cpsc_pkg::MOD_TIMER];
            serial_pin_reset_out <= module_stop_bit_in[cpsc_pkg::MOD_SERIAL];
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    logic no_pin;
    assign no_pin = !rst_low && !hw_low;

    state_code_a: assert property (proc_state_out <= cpsc_pkg::PS_PWRDN)
        else $error("processing state code out of range");
    reset_kind_a: assert property (state_q == cpsc_pkg::ST_RESET && rst_low && !bus_request_pin_low
                                   |=> reset_kind_out == cpsc_pkg::RK_POWER_ON)
        else $error("power-on reset not recognised");
    exc_transient_a: assert property (state_q == cpsc_pkg::ST_EXC |=> state_q != cpsc_pkg::ST_EXC)
        else $error("exception processing lasted more than one cycle");
    reset_vector_a: assert property (state_q == cpsc_pkg::ST_EXC && cause_q == cpsc_pkg::CAUSE_RESET
                                     |-> pc_load_out && pc_load_addr_out == cpsc_pkg::RESET_VECTOR)
        else $error("reset did not load the reset vector");
    pc_save_a: assert property (state_q == cpsc_pkg::ST_EXEC && no_pin && !bus_request_pin_low && gen_exc_in
                                |=> saved_pc_reg_out == $past(pc_in) && saved_status_reg_out == $past(status_in))
        else $error("context not saved on exception");
    handler_addr_a: assert property (state_q == cpsc_pkg::ST_EXEC && no_pin && !bus_request_pin_low && gen_exc_in
                                     |=> pc_load_out && pc_load_addr_out == $past(vector_base_in) + $past(exc_offset_in)
                                         ##1 !pc_load_out)
        else $error("wrong handler address");
    sleep_entry_a: assert property (state_q == cpsc_pkg::ST_EXEC && no_pin && !bus_request_pin_low && !gen_exc_in && !irq_ok &&
                                    halt_exec_in && !standby_select_bit_in
                                    |=> state_q == cpsc_pkg::ST_SLEEP && core_halt_out && periph_clk_en_out)
        else $error("sleep not entered correctly");
    sleep_wake_a: assert property (state_q == cpsc_pkg::ST_SLEEP && no_pin && irq_ok
                                   |=> state_q == cpsc_pkg::ST_EXC && pc_load_out)
        else $error("sleep wake-up skipped exception processing");
    standby_entry_a: assert property (state_q == cpsc_pkg::ST_EXEC && no_pin && !bus_request_pin_low && !gen_exc_in &&
                                      !irq_ok && halt_exec_in && standby_select_bit_in
                                      |=> state_q == cpsc_pkg::ST_STANDBY && !osc_en_out && !periph_clk_en_out)
        else $error("standby not entered correctly");
    osc_load_a: assert property (state_q == cpsc_pkg::ST_STANDBY && no_pin && irq_ok &&
                                 osc_wait_cycles_in != cpsc_pkg::WAIT_ZERO
                                 |=> state_q == cpsc_pkg::ST_OSCWAIT && wait_q == $past(osc_wait_cycles_in))
        else $error("watchdog stabilization time not loaded");
    osc_count_a: assert property (state_q == cpsc_pkg::ST_OSCWAIT && no_pin && wait_q > cpsc_pkg::WAIT_ONE
                                  |=> state_q == cpsc_pkg::ST_OSCWAIT && wait_q == $past(wait_q) - cpsc_pkg::WAIT_ONE)
        else $error("stabilization wait left early");
    hw_standby_a: assert property (hw_low && !rst_low
                                   |=> state_q == cpsc_pkg::ST_HWSTBY && !periph_clk_en_out &&
                                       !module_clk_en_out[cpsc_pkg::MOD_TIMER] &&
                                       !module_clk_en_out[cpsc_pkg::MOD_SERIAL])
        else $error("hardware standby did not halt the modules");
    serial_gate_a: assert property (module_stop_bit_in[cpsc_pkg::MOD_SERIAL] ##1
                                    (state_q == cpsc_pkg::ST_EXEC || state_q == cpsc_pkg::ST_SLEEP)
                                    |-> !module_clk_en_out[cpsc_pkg::MOD_SERIAL] && serial_pin_reset_out)
        else $error("serial module not stopped");
    reset_ungate_a: assert property (state_q == cpsc_pkg::ST_RESET |-> module_clk_en_out == cpsc_pkg::MOD_ALL_ON)
        else $error("clock gating survived reset");
    bus_release_a: assert property (state_q == cpsc_pkg::ST_EXEC && no_pin && bus_request_pin_low
                                    |=> state_q == cpsc_pkg::ST_BUSREL && bus_grant_out)
        else $error("bus request not granted");
    masked_stay_a: assert property (state_q == cpsc_pkg::ST_SLEEP && no_pin && !irq_ok
                                    |=> state_q == cpsc_pkg::ST_SLEEP)
        else $error("masked request woke sleep");

endmodule

// ---- tb/cpsc_far_end.sv ----
// Far-side model: interrupt source, reset pin and bus requesting master.
// Assumes bench commands change just after rising edges of the system clock.
`timescale 1ns/10ps
// =====================================================================
// Pin and request model
module cpsc_far_end (
    input  wire logic       clk_in,
    input  wire logic       raise_in,
    input  wire logic       ack_in,
    input  wire logic [1:0] want_in,
    output logic            irq_out = 1'h0,
    output logic      [1:0] pin_n_out = 2'h3
);
    // A request stays pending until a handler is loaded, as a real source would.
    always @(posedge clk_in) begin
        if (raise_in || ack_in) irq_out <= raise_in;
        pin_n_out <= ~want_in;
    end
endmodule

// ---- tb/cpsc_top_bench.sv ----
// Self-checking bench for the processing state controller.
// Assumes the far-side model drives the reset and bus request pins and the bench drives the core side and the hardware standby pin.
`timescale 1ns/10ps
module cpsc_top_bench;
    logic        ref_clk_in = 1'h0, arst_n_in = 1'h0, hw_standby_pin_n_in = 1'h1, halt_exec_in = 1'h0;
    logic        standby_select_bit_in = 1'h0, gen_exc_in = 1'h0, up = 1'h0, osc_en_out, bus_grant_out;
    logic        irq_req_in, reset_kind_out, pc_load_out, core_halt_out, periph_clk_en_out;
    logic        reset_pin_n_in, bus_request_pin_n_in, timer_pin_hold_out, serial_pin_reset_out;
    logic [1:0]  want = 2'h0;
    logic [2:0]  module_stop_bit_in = 3'h0, proc_state_out, module_clk_en_out;
    logic [3:0]  irq_level_in = 4'h2, irq_mask_in = 4'h2;
    logic [15:0] osc_wait_cycles_in = 16'h0020;
    logic [31:0] pc_in = 32'h0, status_in = 32'h0, vector_base_in = 32'h0, exc_offset_in = 32'h0;
    logic [31:0] irq_offset_in = 32'h0, pc_load_addr_out, saved_pc_reg_out, saved_status_reg_out;
    integer      seed = 32'h9f1d96d6;
    int          fail_count = 0, checks_done = 0, cyc = 0, n;
    cpsc_top cpsc_top_i (.*);
    cpsc_far_end cpsc_far_end_i (.clk_in(ref_clk_in), .raise_in(up), .ack_in(pc_load_out), .want_in(want),
        .irq_out(irq_req_in), .pin_n_out({bus_request_pin_n_in, reset_pin_n_in}));
    always #12.5 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic nw(input int k);
        repeat (k) @(negedge ref_clk_in);
    endtask
    // Bounded wait for the handler load; n keeps the cycle count for the caller.
    task automatic wt;
        for (n = 0; pc_load_out !== 1'h1 && n < 700; n++) nw(1);
        chk(pc_load_out, 1'h1);
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            fail_count++;
            stop_test;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk_in);
        arst_n_in <= 1'h1;
        wt;
        chk(pc_load_addr_out, cpsc_pkg::RESET_VECTOR);
        nw(1);
        chk(proc_state_out, cpsc_pkg::PS_EXEC);
        repeat (4) begin
            @(posedge ref_clk_in);
            {pc_in, status_in} <= {$random(seed), $random(seed)};
            {vector_base_in, exc_offset_in} <= {$random(seed), $random(seed)};
            gen_exc_in <= 1'h1;
            @(posedge ref_clk_in) gen_exc_in <= 1'h0;
            nw(1);
            chk(saved_pc_reg_out, pc_in);
            chk(saved_status_reg_out, status_in);
            chk(pc_load_addr_out, vector_base_in + exc_offset_in);
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk_in);
            {halt_exec_in, standby_select_bit_in, irq_level_in} <= {1'h1, s[0], 4'h2};
            irq_offset_in <= $random(seed);
            @(posedge ref_clk_in) {halt_exec_in, standby_select_bit_in, up} <= {1'h0, !s[0], 1'h1};
            @(posedge ref_clk_in) up <= 1'h0;
            nw(8);
            chk(proc_state_out, cpsc_pkg::PS_PWRDN);
            chk(osc_en_out, !s[0]);
            @(posedge ref_clk_in) irq_level_in <= 4'h5;
            wt;
            chk(n > s * 32, 1'h1);
            chk(pc_load_addr_out, vector_base_in + irq_offset_in);
        end
        @(posedge ref_clk_in) {want, module_stop_bit_in} <= {2'h2, 3'h5};
        nw(6);
        chk({bus_grant_out, proc_state_out}, {1'h1, cpsc_pkg::PS_BUSREL});
        chk(module_clk_en_out, 3'h2);
        @(posedge ref_clk_in) want <= 2'h3;
        nw(6);
        chk({reset_kind_out, module_clk_en_out}, {cpsc_pkg::RK_MANUAL, 3'h7});
        @(posedge ref_clk_in) {want, module_stop_bit_in} <= {2'h0, 3'h0};
        wt;
        chk(pc_load_addr_out, cpsc_pkg::RESET_VECTOR);
        @(posedge ref_clk_in) want <= 2'h1;
        nw(6);
        chk({bus_grant_out, reset_kind_out}, {1'h0, cpsc_pkg::RK_POWER_ON});
        @(posedge ref_clk_in) {want, hw_standby_pin_n_in} <= {2'h0, 1'h0};
        nw(6);
        chk({proc_state_out, module_clk_en_out, osc_en_out}, {cpsc_pkg::PS_PWRDN, 3'h2, 1'h0});
        @(posedge ref_clk_in) hw_standby_pin_n_in <= 1'h1;
        wt;
        chk(n >= cpsc_pkg::OSC_STAB_CYC - 1, 1'h1);
        chk(pc_load_addr_out, cpsc_pkg::RESET_VECTOR);
        stop_test;
    end
endmodule
